// File: rtl/timer_rt_pwm.sv
`timescale 1ns/1ps
`include "tmr_consts.svh"
// What this block does
// [RQ1] trigger-generation channel counts up in capture mode, feeding the lower channel
// [RQ2] counter starts from zero on start write when stopped, or valid edge
// [RQ3] start raises interrupt and drives output only if start-irq select is one
// [RQ4] edge or running start write: capture, clear counter, interrupt, same cycle
// [RQ5] trigger channel pin takes its real-time value at each interrupt; the code updates it only while output_enable_bit is set
// [RQ6] lower pin takes its value only when enabled and not a trigger channel
// [RQ7] writing the lower real-time value alone never moves the pin
// [RQ8] lower channel counter, data and interrupt stay free for other use
// [RQ9] overflow flag set at capture if counter wrapped since last, else cleared
// [RQ10] stop clears enabled flag, freezes counter, overflow flag and pin
// [RQ11] start and stop bits are strobes that read back as zero
// [RQ12] software changes only edge select while counting; values any time
// [RQ13] channels 0-7 pick clock a/b, 8-11 pick c/d, one bit each
// [RQ14] six-phase pwm: eight channels, outputs on slaves 2-7, slave 1 free
// [RQ15] pwm period is master data plus one count clocks
// [RQ16] duty is slave over master plus one; 0 gives 0%, large gives 100%
// [RQ17] master is an interval timer, reloads and interrupts each period
// [RQ18] slave loads on master interrupt, counts down, interrupts at zero, stops
// [RQ19] slave output active after master interrupt, inactive at zero
// [RQ20] new data values apply only from the next master interrupt
// [RQ21] software writes master and slave data right after a master interrupt
// [RQ22] with modulated output, slave channel 1 is the trigger channel
// [RQ23] timer input is synchronised before edge detection, one event per edge
module timer_rt_pwm
  import tmr_pkg::*;
(
  input  wire logic        clock,             // 100 MHz
  input  wire logic        rstn,              // sync reset, low
  input  wire logic        unit_clock_enable, // freezes all state when low
  input  wire logic        prescaled_clock_a, // count enable, ch 0-7
  input  wire logic        prescaled_clock_b, // count enable, ch 0-7
  input  wire logic        prescaled_clock_c, // count enable, ch 8-11
  input  wire logic        prescaled_clock_d, // count enable, ch 8-11
  input  wire logic        timer_input_pin,   // async edge source
  input  wire logic        cyc_i,             // wishbone cycle
  input  wire logic        stb_i,             // wishbone strobe
  input  wire logic        we_i,              // wishbone write
  input  wire logic [7:0]  adr_i,             // byte address
  input  wire logic [3:0]  sel_i,             // byte lanes
  input  wire logic [31:0] dat_i,             // write data
  output logic      [31:0] dat_o,             // read data
  output logic             ack_o,             // wishbone ack
  output logic             channel_interrupt, // trigger channel pulse
  output logic             master_interrupt,  // master period pulse
  output logic [5:0]       slave_interrupt,   // slave 2-7 zero pulses
  output logic             timer_output_pin,  // trigger channel pin
  output logic             lower_timer_output_pin, // lower channel pin
  output logic [5:0]       pwm_out            // slave 2-7 pwm, active high
);
  mode_t       mode_reg;
  logic [11:0] clksel_reg;
  logic [15:0] count_reg, channel_data_reg, master_data_reg, mcnt_reg;
  logic [15:0] slave_data_reg [`N_SLAVE];
  trg_state_t  trg_reg;
  pwm_state_t  pwm_reg;
  logic        ovf_seen_reg, counter_overflow_flag, lower_level_reg;
  logic        ack_reg, irq_reg, mirq_reg, wr, edge_pulse;
  logic        start_wr, stop_wr, pstop, start_evt, cap_evt, irq_evt;
  logic        wrap_now, trg_tick, m_tick, m_load;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic tick_of(input int ch);
    if (ch < `CH_SPLIT) begin // [RQ13]
      tick_of = clksel_reg[ch] ? prescaled_clock_b : prescaled_clock_a;
    end else begin
      tick_of = clksel_reg[ch] ? prescaled_clock_d : prescaled_clock_c;
    end
  endfunction
  function automatic logic [15:0] lanes16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    lanes16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // write lands on the edge where the master samples ack
  assign wr    = cyc_i & stb_i & we_i & ack_reg & unit_clock_enable;
  assign ack_o = ack_reg;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else if (unit_clock_enable) begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      dat_o <= `Z32;
    end else if (unit_clock_enable && cyc_i && stb_i && !ack_reg) begin
      if (adr_i == `A_MODE) begin
        dat_o <= {23'h000000, mode_reg};
      end else if (adr_i == `A_CLKSEL) begin
        dat_o <= {20'h00000, clksel_reg};
      end else if (adr_i == `A_CAPT) begin
        dat_o <= {16'h0000, channel_data_reg};
      end else if (adr_i == `A_COUNT) begin
        dat_o <= {16'h0000, count_reg};
      end else if (adr_i == `A_STAT) begin
        dat_o <= {24'h000000, pwm_out[1:0], lower_timer_output_pin,
                  timer_output_pin, pwm_reg, counter_overflow_flag, trg_reg};
      end else if (adr_i == `A_MDATA) begin
        dat_o <= {16'h0000, master_data_reg};
      end else if (adr_i >= `A_SDATA && adr_i <= `A_SLAST && adr_i[1:0] == 2'b00) begin
        dat_o <= {16'h0000, slave_data_reg[3'((adr_i - `A_SDATA) >> 2)]};
      end else begin
        dat_o <= `Z32; // control strobes and holes read zero [RQ11]
      end
    end
  end
  assign start_wr = wr && adr_i == `A_CTRL && sel_i[0] && dat_i[`C_START];
  assign stop_wr  = wr && adr_i == `A_CTRL && sel_i[0] && dat_i[`C_STOP];
  assign pstop    = wr && adr_i == `A_CTRL && sel_i[0] && dat_i[`C_PSTOP];
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_reg   <= `MODE_RST;
      clksel_reg <= `CSEL_RST;
    end else if (wr) begin
      if (adr_i == `A_MODE) begin
        mode_reg <= {sel_i[1] ? dat_i[8] : mode_reg[8],
                     sel_i[0] ? dat_i[7:0] : mode_reg[7:0]};
      end else if (adr_i == `A_CLKSEL) begin
        clksel_reg <= {sel_i[1] ? dat_i[11:8] : clksel_reg[11:8],
                       sel_i[0] ? dat_i[7:0] : clksel_reg[7:0]};
      end
    end
  end
  // data registers: read only at reload, so writes wait a period [RQ20]
  always_ff @(posedge clock) begin
    if (!rstn) begin
      master_data_reg <= `Z16;
      for (int i = 0; i < `N_SLAVE; i++) begin
        slave_data_reg[i] <= `Z16;
      end
    end else if (wr) begin
      if (adr_i == `A_MDATA) begin
        master_data_reg <= lanes16(master_data_reg, dat_i, sel_i);
      end else if (adr_i >= `A_SDATA && adr_i <= `A_SLAST && adr_i[1:0] == 2'b00) begin
        slave_data_reg[3'((adr_i - `A_SDATA) >> 2)] <=
          lanes16(slave_data_reg[3'((adr_i - `A_SDATA) >> 2)], dat_i, sel_i);
      end
    end
  end
  // ----------------------------------------
  // real-time trigger channel
  // ----------------------------------------
  edge_sync edge_sync_inst (
    .clock  (clock),
    .rstn   (rstn),
    .ce     (unit_clock_enable),
    .pin    (timer_input_pin),
    .sel_hi (mode_reg.edge_select_hi),
    .sel_lo (mode_reg.edge_select_lo),
    .edge_o (edge_pulse)
  ); // [RQ23]
  assign trg_tick  = unit_clock_enable & tick_of(`CH_TRIG);
  assign start_evt = mode_reg.trigger_gen_select && trg_reg == TRG_STOP &&
                     (start_wr || edge_pulse) && !stop_wr; // [RQ2]
  assign cap_evt   = mode_reg.trigger_gen_select && trg_reg == TRG_RUN &&
                     (start_wr || edge_pulse) && !stop_wr; // [RQ1] [RQ4]
  assign irq_evt   = cap_evt | (start_evt & mode_reg.start_irq_select); // [RQ3]
  assign wrap_now  = trg_reg == TRG_RUN && trg_tick && count_reg == `MAX16;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      trg_reg <= TRG_STOP;
    end else if (unit_clock_enable) begin
      if (stop_wr) begin
        trg_reg <= TRG_STOP; // [RQ10]
      end else if (start_evt) begin
        trg_reg <= TRG_RUN;
      end
    end
  end
  // stop beats the count tick so the value freezes exactly
  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_reg        <= `Z16;
      channel_data_reg <= `Z16;
    end else if (unit_clock_enable && !stop_wr) begin
      if (start_evt) begin
        count_reg <= `Z16; // [RQ2]
      end else if (cap_evt) begin
        channel_data_reg <= count_reg; // [RQ4]
        count_reg        <= `Z16;
      end else if (trg_reg == TRG_RUN && trg_tick) begin
        count_reg <= count_reg + `ONE16;
      end
    end
  end
  // a wrap in the capture cycle still counts: set wins over clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ovf_seen_reg          <= 1'b0;
      counter_overflow_flag <= 1'b0;
    end else if (unit_clock_enable && !stop_wr) begin
      if (start_evt) begin
        ovf_seen_reg <= 1'b0;
      end else if (cap_evt) begin
        counter_overflow_flag <= ovf_seen_reg | wrap_now; // [RQ9]
        ovf_seen_reg          <= 1'b0;
      end else if (wrap_now) begin
        ovf_seen_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_reg          <= 1'b0;
      timer_output_pin <= 1'b0;
      lower_level_reg  <= 1'b0;
    end else if (unit_clock_enable) begin
      irq_reg <= irq_evt;
      if (irq_evt && mode_reg.output_enable_bit) begin
        timer_output_pin <= mode_reg.rt_output_value_bit; // [RQ5]
      end
      // lower value bit is sampled only here, never on write [RQ7]
      if (irq_evt && mode_reg.rt_output_enable && !mode_reg.lower_trigger_gen_select) begin
        lower_level_reg <= mode_reg.lower_rt_output_value_bit; // [RQ6]
      end
    end
  end
  assign channel_interrupt = irq_reg;
  // lower pin shares slave 2's pin; the lower counter is untouched [RQ8] [RQ22]
  assign lower_timer_output_pin = mode_reg.rt_output_enable ? lower_level_reg : pwm_out[0];
  // ----------------------------------------
  // six-phase pwm master
  // ----------------------------------------
  assign m_tick = unit_clock_enable & tick_of(`CH_MASTER);
  assign m_load = !pstop && m_tick && (pwm_reg == PW_ARM ||
                  (pwm_reg == PW_RUN && mcnt_reg == `Z16)); // [RQ17]
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pwm_reg <= PW_STOP;
    end else if (unit_clock_enable) begin
      case (pwm_reg)
        PW_STOP: begin
          if (wr && adr_i == `A_CTRL && sel_i[0] && dat_i[`C_PSTART]) begin
            pwm_reg <= PW_ARM; // [RQ14]
          end
        end
        PW_ARM: begin
          if (pstop) begin
            pwm_reg <= PW_STOP;
          end else if (m_tick) begin
            pwm_reg <= PW_RUN;
          end
        end
        PW_RUN: begin
          if (pstop) begin
            pwm_reg <= PW_STOP;
          end
        end
        default: pwm_reg <= PW_STOP;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mcnt_reg <= `Z16;
      mirq_reg <= 1'b0;
    end else if (unit_clock_enable) begin
      mirq_reg <= m_load;
      if (m_load) begin
        mcnt_reg <= master_data_reg; // [RQ15]
      end else if (pwm_reg == PW_RUN && m_tick && !pstop) begin
        mcnt_reg <= mcnt_reg - `ONE16;
      end
    end
  end
  assign master_interrupt = mirq_reg;
  // ----------------------------------------
  // six pwm slaves
  // ----------------------------------------
  for (genvar g = 0; g < `N_SLAVE; g++) begin : g_slave
    logic [15:0] scnt_reg;
    logic        srun_reg, out_reg, sirq_reg, s_tick, s_done;
    assign s_tick = unit_clock_enable & tick_of(`CH_SLAVE + g);
    assign s_done = srun_reg && s_tick && !m_load && !pstop && scnt_reg == `ONE16;
    always_ff @(posedge clock) begin
      if (!rstn) begin
        scnt_reg <= `Z16;
        srun_reg <= 1'b0;
        out_reg  <= 1'b0;
        sirq_reg <= 1'b0;
      end else if (unit_clock_enable) begin
        sirq_reg <= s_done;
        if (pstop) begin
          srun_reg <= 1'b0; // output held, not reset
        end else if (m_load) begin
          scnt_reg <= slave_data_reg[g]; // [RQ18]
          srun_reg <= slave_data_reg[g] != `Z16;
          out_reg  <= slave_data_reg[g] != `Z16; // [RQ16] [RQ19]
        end else if (s_done) begin
          scnt_reg <= `Z16;
          srun_reg <= 1'b0;
          out_reg  <= 1'b0; // [RQ19]
        end else if (srun_reg && s_tick) begin
          scnt_reg <= scnt_reg - `ONE16;
        end
      end
    end
    assign pwm_out[g]         = out_reg;
    assign slave_interrupt[g] = sirq_reg;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_cap_clear;
    cap_evt |=> count_reg == `Z16 && channel_data_reg == $past(count_reg);
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capture wrong"); // [RQ4]
  property p_cap_irq;
    cap_evt |=> channel_interrupt;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("no capture irq"); // [RQ4]
  property p_start_quiet;
    start_evt && !mode_reg.start_irq_select |=> !channel_interrupt;
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("start irq"); // [RQ3]
  property p_pin_val;
    channel_interrupt && $past(mode_reg.output_enable_bit) |->
      timer_output_pin == $past(mode_reg.rt_output_value_bit);
  endproperty
  a_pin_val: assert property (p_pin_val) else $error("pin value"); // [RQ5]
  property p_lower_hold;
    !channel_interrupt |-> $stable(lower_level_reg);
  endproperty
  a_lower_hold: assert property (p_lower_hold) else $error("lower moved"); // [RQ7]
  property p_stop_freeze;
    stop_wr |=> trg_reg == TRG_STOP && $stable(count_reg) &&
                $stable(counter_overflow_flag) && $stable(timer_output_pin);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("stop"); // [RQ10]
  property p_ovf;
    cap_evt |=> counter_overflow_flag == $past(ovf_seen_reg | wrap_now);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag"); // [RQ9]
  property p_ctrl_zero;
    cyc_i && stb_i && !ack_reg && adr_i == `A_CTRL && unit_clock_enable
      |=> dat_o == `Z32;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("strobe read"); // [RQ11]
  property p_reload;
    m_load |=> mcnt_reg == $past(master_data_reg) ##0 master_interrupt;
  endproperty
  a_reload: assert property (p_reload) else $error("reload"); // [RQ15]
  property p_slave_off;
    g_slave[0].s_done |=> !pwm_out[0] ##0 slave_interrupt[0];
  endproperty
  a_slave_off: assert property (p_slave_off) else $error("slave end"); // [RQ19]
  c_capture: cover property (cap_evt);
  c_overflow: cover property (cap_evt && ovf_seen_reg);
  c_period: cover property (master_interrupt ##[1:40] master_interrupt);
  c_pulse: cover property (pwm_out[0] ##1 !pwm_out[0]);
endmodule

// File: rtl/tmr_consts.svh
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define A_CTRL    8'h00
`define A_MODE    8'h04
`define A_CLKSEL  8'h08
`define A_CAPT    8'h0C
`define A_COUNT   8'h10
`define A_STAT    8'h14
`define A_MDATA   8'h18
`define A_SDATA   8'h1C
`define A_SLAST   8'h30
// ----------------------------------------
// control strobe bits
// ----------------------------------------
`define C_START   0
`define C_STOP    1
`define C_PSTART  2
`define C_PSTOP   3
// ----------------------------------------
// values and channel map
// ----------------------------------------
`define Z16       16'h0000
`define ONE16     16'h0001
`define MAX16     16'hFFFF
`define Z32       32'h0000_0000
`define MODE_RST  9'h000
`define CSEL_RST  12'h000
`define CH_MASTER 0
`define CH_TRIG   1
`define CH_SLAVE  2
`define N_SLAVE   6
`define CH_SPLIT  8
`endif

// File: rtl/tmr_pkg.sv
package tmr_pkg;
  // mode register layout, lsb first from the bottom of the list
  typedef struct packed {
    logic output_enable_bit;
    logic lower_trigger_gen_select;
    logic rt_output_enable;
    logic lower_rt_output_value_bit;
    logic rt_output_value_bit;
    logic edge_select_hi;
    logic edge_select_lo;
    logic start_irq_select;
    logic trigger_gen_select;
  } mode_t;

  typedef enum logic {
    TRG_STOP = 1'b0,
    TRG_RUN  = 1'b1
  } trg_state_t;

  typedef enum logic [1:0] {
    PW_STOP = 2'b00,
    PW_ARM  = 2'b01,
    PW_RUN  = 2'b10
  } pwm_state_t;
endpackage

// File: rtl/edge_sync.sv
`timescale 1ns/1ps
module edge_sync
  import tmr_pkg::*;
(
  input  wire logic clock,  // system clock
  input  wire logic rstn,   // sync reset, low
  input  wire logic ce,     // freezes state when low
  input  wire logic pin,    // async timer input pin
  input  wire logic sel_hi, // edge select high bit
  input  wire logic sel_lo, // edge select low bit
  output logic      edge_o  // one-cycle valid edge
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic rise;
  logic fall;

  // ----------------------------------------
  // two-stage synchroniser and history
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // one edge yields one pulse: compared only past the synchroniser
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;

  always_comb begin
    if (!ce) begin
      edge_o = 1'b0;
    end else if (sel_hi) begin
      edge_o = rise | fall;
    end else if (sel_lo) begin
      edge_o = rise;
    end else begin
      edge_o = fall;
    end
  end
endmodule

// File: verif/edge_source.sv
`timescale 1ns/1ps
module edge_source (
  input  wire logic clock, // bench clock
  input  wire logic level, // level the bench asks for
  output logic      pin    // timer input pin
);
  // pin moves only right after an edge, like a synchronous source
  always_ff @(posedge clock) begin
    pin <= level;
  end
endmodule

// File: verif/timer_realtime_out_and_six_phase_pwm_tb.sv
`timescale 1ns/1ps
`include "tmr_consts.svh"
module timer_realtime_out_and_six_phase_pwm_tb;
  import tmr_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        tick = 1'b0;
  logic        pin_req = 1'b0;
  logic        timer_input_pin;
  logic [2:0]  rnd = 3'h0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        channel_interrupt;
  logic        master_interrupt;
  logic [5:0]  slave_interrupt;
  logic [5:0]  pwm_out;
  logic        timer_output_pin;
  logic        lower_timer_output_pin;
  logic        win = 1'b0;
  logic [63:0] expq[$];
  int          bad_count = 0;
  int          total_checks = 0;
  int          seed = 32'hbffa07d6;
  int          irq_seen = 0;
  int          mirq = 0;
  int          hi[6];
  int          sirq[6];

  timer_rt_pwm timer_rt_pwm_inst (
    .clock(clock), .rstn(rstn), .unit_clock_enable(1'b1),
    .prescaled_clock_a(tick), .prescaled_clock_b(rnd[0]),
    .prescaled_clock_c(rnd[1]), .prescaled_clock_d(rnd[2]),
    .timer_input_pin(timer_input_pin), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .channel_interrupt(channel_interrupt), .master_interrupt(master_interrupt),
    .slave_interrupt(slave_interrupt), .timer_output_pin(timer_output_pin),
    .lower_timer_output_pin(lower_timer_output_pin), .pwm_out(pwm_out));

  edge_source edge_source_inst (.clock(clock), .level(pin_req), .pin(timer_input_pin));

  always #5 clock = ~clock;

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // read data is compared with the oldest noted expectation
  always @(posedge clock) begin
    rnd <= 3'($random(seed));
    if (ack_o === 1'b1 && !we && expq.size() > 0) begin
      check(dat_o & expq[0][63:32], expq[0][31:0]);
      expq.delete(0);
    end
    if (channel_interrupt === 1'b1) irq_seen++;
    if (win) begin
      mirq += int'(master_interrupt === 1'b1);
      for (int g = 0; g < 6; g++) begin
        hi[g] += int'(pwm_out[g] === 1'b1);
        sirq[g] += int'(slave_interrupt[g] === 1'b1);
      end
    end
  end

  // ----------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("CHECK FAILED at %0t: bus answer missing", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expq.push_back({m, e});
    wb(1'b0, a, `Z32);
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clock);
      tick <= 1'b1;
    end
    @(posedge clock);
    tick <= 1'b0;
  endtask

  // rising edge on the pin, then time for sync and capture to land
  task automatic rise();
    @(posedge clock);
    pin_req <= 1'b0;
    repeat (6) @(posedge clock);
    pin_req <= 1'b1;
    repeat (8) @(posedge clock);
  endtask

  task automatic measure();
    mirq = 0;
    foreach (hi[g]) begin
      hi[g] = 0;
      sirq[g] = 0;
    end
    win <= 1'b1;
    repeat (16) @(posedge clock);
    win <= 1'b0;
    @(posedge clock);
  endtask

  initial begin
    #900000;
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int k;
    k = 1 + int'($unsigned($random(seed)) % 20);
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rd(`A_STAT, `Z32, 32'hFFFFFFFF);
    rd(8'h40, `Z32, 32'hFFFFFFFF);
    wb(1'b1, `A_MODE, 32'h177);
    wb(1'b1, `A_CTRL, 32'h1);
    rd(`A_STAT, 32'h31, 32'hFF);
    rd(`A_CTRL, `Z32, 32'hFFFFFFFF);
    wb(1'b1, `A_MODE, 32'h147);
    rd(`A_STAT, 32'h30, 32'h30);
    ticks(k);
    rd(`A_COUNT, 32'(k), 32'hFFFF);
    rise();
    rd(`A_CAPT, 32'(k), 32'hFFFF);
    rd(`A_COUNT, `Z32, 32'hFFFF);
    rd(`A_STAT, 32'h01, 32'h33);
    ticks(3);
    wb(1'b1, `A_CTRL, 32'h1);
    rd(`A_CAPT, 32'h3, 32'hFFFF);
    wb(1'b1, `A_MODE, 32'h1F7);
    rise();
    rd(`A_STAT, 32'h10, 32'h30);
    check(32'(irq_seen), 32'h4);
    ticks(2);
    wb(1'b1, `A_CTRL, 32'h2);
    ticks(4);
    rd(`A_COUNT, 32'h2, 32'hFFFF);
    rd(`A_STAT, 32'h10, 32'h31);
    wb(1'b1, `A_MODE, 32'h1F5);
    wb(1'b1, `A_CTRL, 32'h1);
    ticks(65539);
    rise();
    rd(`A_CAPT, 32'h3, 32'hFFFF);
    rd(`A_STAT, 32'h03, 32'h03);
    wb(1'b1, `A_CTRL, 32'h1);
    rd(`A_STAT, 32'h01, 32'h03);
    check(32'(irq_seen), 32'h6);
    // six-phase pwm with a count tick on every cycle
    @(posedge clock);
    tick <= 1'b1;
    wb(1'b1, `A_MDATA, 32'h3);
    for (int g = 0; g < 6; g++) wb(1'b1, `A_SDATA + 8'(4 * g), 32'(g));
    wb(1'b1, `A_CTRL, 32'h4);
    repeat (20) @(posedge clock);
    measure();
    check(32'(mirq), 32'h4);
    for (int g = 0; g < 6; g++) check(32'(hi[g]), 32'((g < 4 ? g : 4) * 4));
    for (int g = 0; g < 6; g++) check(32'(sirq[g]), (g == 0 || g > 3) ? `Z32 : 32'h4);
    wb(1'b1, `A_MDATA, 32'h1);
    rd(`A_STAT, 32'h08, 32'h0C);
    repeat (12) @(posedge clock);
    measure();
    check(32'(mirq), 32'h8);
    check(32'(hi[1]), 32'h8);
    check(32'(hi[2]), 32'h10);
    wb(1'b1, `A_CTRL, 32'h8);
    rd(`A_STAT, `Z32, 32'h0C);
    end_of_test();
  end
endmodule
